// ### rsx_alu.sv
/*
 Combinational result unit: rotate, swap and xor with zero detect.
 Assumes operands are stable for the whole instruction cycle.
*/
`timescale 1ns/10ps
`include "rsx_params.svh"
module rsx_alu #(
  parameter int DATA_W = `RSX_DATA_W
) (
  input wire rsx_pkg::rsx_op_t op_in, // Operation
  input wire logic [DATA_W-1:0] w_in, // Working register
  input wire logic [DATA_W-1:0] file_in, // File register value
  input wire logic [DATA_W-1:0] literal_in, // Immediate
  input wire logic carry_in, // Current carry
  output logic [DATA_W-1:0] result_out, // Result
  output logic carry_out, // New carry for rotate
  output logic zero_out // Result is zero
);
  import rsx_pkg::*;
  localparam int HALF = DATA_W / 2;

  wire [DATA_W-1:0] rot_res = {carry_in, file_in[DATA_W-1:1]};
  wire [DATA_W-1:0] swap_res = {file_in[HALF-1:0], file_in[DATA_W-1:HALF]};
  wire [DATA_W-1:0] xorf_res = w_in ^ file_in;
  wire [DATA_W-1:0] xorl_res = w_in ^ literal_in;

  // rotate through carry, nibble swap, xor
  assign result_out = (op_in == RSX_OP_ROTATE_RIGHT_CARRY) ? rot_res :
                      (op_in == RSX_OP_NIBBLE_SWAP) ? swap_res :
                      (op_in == RSX_OP_XOR_FILE) ? xorf_res :
                      (op_in == RSX_OP_XOR_LITERAL) ? xorl_res : w_in;
  assign carry_out = file_in[0];
  assign zero_out = (result_out == '0);
endmodule : rsx_alu

// ### rsx_exec.sv
/*
 Execution stage for rotate right through carry, nibble swap, xor with file
 or literal, and port direction load. Holds W, carry, zero and two direction
 registers; file storage lives outside and is read combinationally.
 Assumes one instruction per cycle presented on exec_valid_in, and that the
 file array applies file_wr_en_out / file_wr_addr_out / file_wr_data_out.
*/
`timescale 1ns/10ps
`include "rsx_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - Rotate file right through carry; old carry into MSB, LSB out to carry.
// - Destination bit 0 writes W, 1 writes file register 0 to 31.
// - Swap nibbles of file register to chosen destination; flags untouched.
// - Copy W to direction register selected by 6 or 7; flags untouched.
// - XOR W with file, store per destination bit, update zero only.
// - XOR W with 8-bit literal into W, update zero only.
module rsx_exec #(
  parameter int DATA_W = `RSX_DATA_W,
  parameter int ADDR_W = `RSX_ADDR_W
) (
  input wire logic sys_clk_in, // Core clock
  input wire logic reset_n_in, // Sync reset, active low
  input wire logic exec_valid_in, // Instruction present this cycle
  input wire rsx_pkg::rsx_op_t op_in, // Operation
  input wire logic dest_in, // Destination bit
  input wire logic [ADDR_W-1:0] file_addr_in, // File address
  input wire logic [DATA_W-1:0] file_data_in, // File read data at file_addr_in
  input wire logic [DATA_W-1:0] literal_in, // Immediate / selector
  output logic [DATA_W-1:0] w_out, // Working register
  output logic carry_out, // Carry flag
  output logic zero_out, // Zero flag
  output logic [DATA_W-1:0] dir6_out, // Direction register 6
  output logic [DATA_W-1:0] dir7_out, // Direction register 7
  output logic file_wr_en_out, // File write strobe
  output logic [ADDR_W-1:0] file_wr_addr_out, // File write address
  output logic [DATA_W-1:0] file_wr_data_out // File write data
);
  import rsx_pkg::*;

  logic [DATA_W-1:0] w_reg;
  logic carry_reg;
  logic zero_reg;
  logic [DATA_W-1:0] dir6_reg;
  logic [DATA_W-1:0] dir7_reg;
  logic wr_en_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [DATA_W-1:0] wr_data_reg;
  logic [DATA_W-1:0] alu_res;
  logic alu_carry;
  logic alu_zero;

  rsx_alu #(.DATA_W(DATA_W)) u_alu (
    .op_in(op_in),
    .w_in(w_reg),
    .file_in(file_data_in),
    .literal_in(literal_in),
    .carry_in(carry_reg),
    .result_out(alu_res),
    .carry_out(alu_carry),
    .zero_out(alu_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire is_rot = exec_valid_in && (op_in == RSX_OP_ROTATE_RIGHT_CARRY);
  wire is_swap = exec_valid_in && (op_in == RSX_OP_NIBBLE_SWAP);
  wire is_xorf = exec_valid_in && (op_in == RSX_OP_XOR_FILE);
  wire is_xorl = exec_valid_in && (op_in == RSX_OP_XOR_LITERAL);
  wire is_dir = exec_valid_in && (op_in == RSX_OP_PORT_DIRECTION_LOAD);
  wire file_op = is_rot || is_swap || is_xorf;
  wire to_file = file_op && (dest_in == `RSX_DEST_F_SEL);
  wire to_w = (file_op && (dest_in == `RSX_DEST_W_SEL)) || is_xorl;
  // selector decode; other values are ignored
  wire sel6 = is_dir && (literal_in[2:0] == `RSX_DIR_SEL_LO) && (literal_in[DATA_W-1:3] == '0);
  wire sel7 = is_dir && (literal_in[2:0] == `RSX_DIR_SEL_HI) && (literal_in[DATA_W-1:3] == '0);
  wire z_upd = is_xorf || is_xorl;

  wire [DATA_W-1:0] w_next = to_w ? alu_res : w_reg;
  wire carry_next = is_rot ? alu_carry : carry_reg;
  wire zero_next = z_upd ? alu_zero : zero_reg;
  wire [DATA_W-1:0] dir6_next = sel6 ? w_reg : dir6_reg;
  wire [DATA_W-1:0] dir7_next = sel7 ? w_reg : dir7_reg;

  ////////////////////////////////////////////////////////////////////////////
  // State
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      w_reg <= `RSX_W_RESET;
      carry_reg <= `RSX_C_RESET;
      zero_reg <= `RSX_Z_RESET;
      dir6_reg <= `RSX_DIR_RESET;
      dir7_reg <= `RSX_DIR_RESET;
    end else begin
      w_reg <= w_next;
      carry_reg <= carry_next;
      zero_reg <= zero_next;
      dir6_reg <= dir6_next;
      dir7_reg <= dir7_next;
    end
  end

  // File write port registered so data outputs come from flops
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      wr_en_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
    end else begin
      wr_en_reg <= to_file;
      wr_addr_reg <= file_addr_in;
      wr_data_reg <= alu_res;
    end
  end

  assign w_out = w_reg;
  assign carry_out = carry_reg;
  assign zero_out = zero_reg;
  assign dir6_out = dir6_reg;
  assign dir7_out = dir7_reg;
  assign file_wr_en_out = wr_en_reg;
  assign file_wr_addr_out = wr_addr_reg;
  assign file_wr_data_out = wr_data_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_rot_result;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (is_rot && dest_in == 1'b0) |=>
      (w_reg == {$past(carry_reg), $past(file_data_in[DATA_W-1:1])})
      && (carry_reg == $past(file_data_in[0])) && $stable(zero_reg);
  endproperty
  a_rot_result: assert property (p_rot_result) else $error("rotate result wrong");

  property p_dest_file;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (file_op && dest_in == 1'b1) |=> file_wr_en_out && $stable(w_reg)
      && (file_wr_addr_out == $past(file_addr_in));
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file destination wrong");

  property p_no_stray_write;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    !to_file |=> !file_wr_en_out;
  endproperty
  a_no_stray_write: assert property (p_no_stray_write) else $error("stray file write");

  property p_swap;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (is_swap && dest_in == 1'b1) |=>
      (file_wr_data_out == {$past(file_data_in[3:0]), $past(file_data_in[7:4])})
      && $stable(carry_reg) && $stable(zero_reg);
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");

  property p_dir_load;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (is_dir && literal_in == 8'h07) |=> (dir7_reg == $past(w_reg))
      && $stable(dir6_reg) && $stable(carry_reg) && $stable(zero_reg);
  endproperty
  a_dir_load: assert property (p_dir_load) else $error("direction load wrong");

  property p_xor_file;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (is_xorf && dest_in == 1'b0) |=> (w_reg == ($past(w_reg) ^ $past(file_data_in)))
      && $stable(carry_reg);
  endproperty
  a_xor_file: assert property (p_xor_file) else $error("xor file wrong");

  property p_xor_lit;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    is_xorl |=> (w_reg == ($past(w_reg) ^ $past(literal_in))) && !file_wr_en_out;
  endproperty
  a_xor_lit: assert property (p_xor_lit) else $error("xor literal wrong");

  property p_zero;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    is_xorl |=> (zero_reg == (w_reg == 8'h00));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_rot_to_file;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (is_rot && dest_in == 1'b1) |=>
      (file_wr_data_out == {$past(carry_reg), $past(file_data_in[DATA_W-1:1])})
      && (carry_reg == $past(file_data_in[0])) && $stable(w_reg);
  endproperty
  a_rot_to_file: assert property (p_rot_to_file) else $error("rotate to file");

  property p_carry_hold;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    !is_rot |=> $stable(carry_reg);
  endproperty
  a_carry_hold: assert property (p_carry_hold) else $error("carry moved");

  property p_swap_to_w;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (is_swap && dest_in == 1'b0) |=>
      (w_reg == {$past(file_data_in[3:0]), $past(file_data_in[7:4])}) && !file_wr_en_out;
  endproperty
  a_swap_to_w: assert property (p_swap_to_w) else $error("swap to w wrong");

  property p_dir6_load;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (is_dir && literal_in == 8'h06) |=> (dir6_reg == $past(w_reg))
      && $stable(dir7_reg) && $stable(w_reg);
  endproperty
  a_dir6_load: assert property (p_dir6_load) else $error("direction 6 wrong");

  property p_dir_refused;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (is_dir && literal_in != 8'h06 && literal_in != 8'h07) |=>
      $stable(dir6_reg) && $stable(dir7_reg);
  endproperty
  a_dir_refused: assert property (p_dir_refused) else $error("bad selector");

  property p_xor_file_dest;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    (is_xorf && dest_in == 1'b1) |=>
      (file_wr_data_out == ($past(w_reg) ^ $past(file_data_in)))
      && $stable(w_reg) && $stable(carry_reg);
  endproperty
  a_xor_file_dest: assert property (p_xor_file_dest) else $error("xor to file");

  property p_zero_hold;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    !(is_xorf || is_xorl) |=> $stable(zero_reg);
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("zero moved");

  property p_zero_file;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    is_xorf |=> (zero_reg == (($past(w_reg) ^ $past(file_data_in)) == 8'h00));
  endproperty
  a_zero_file: assert property (p_zero_file) else $error("zero after xor file");
endmodule : rsx_exec

// ### rsx_exec_tb.sv
/*
 Self-checking bench for rsx_exec: rotate, swap, xor and direction load.
 Assumes rsx_params.svh on the include path and rsx_pkg compiled first.
*/
`timescale 1ns/10ps
`include "rsx_params.svh"
module rsx_exec_tb;
  import rsx_pkg::*;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic exec_valid_in = 1'b0;
  logic dest_in = 1'b0;
  rsx_op_t op_in = RSX_OP_NONE;
  logic [4:0] file_addr_in = 5'h00;
  logic [7:0] file_data_in = 8'h00;
  logic [7:0] literal_in = 8'h00;
  logic [7:0] w_out, dir6_out, dir7_out, file_wr_data_out;
  logic carry_out, zero_out, file_wr_en_out;
  logic [4:0] file_wr_addr_out;
  int fails = 0;
  int checked = 0;
  rsx_exec u_dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .exec_valid_in(exec_valid_in), .op_in(op_in), .dest_in(dest_in),
    .file_addr_in(file_addr_in), .file_data_in(file_data_in),
    .literal_in(literal_in), .w_out(w_out), .carry_out(carry_out),
    .zero_out(zero_out), .dir6_out(dir6_out), .dir7_out(dir7_out),
    .file_wr_en_out(file_wr_en_out), .file_wr_addr_out(file_wr_addr_out),
    .file_wr_data_out(file_wr_data_out));
  initial begin
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: flag %b want %b", $time, got, exp);
    end
  endtask : chk1
  task automatic summarize;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // Called just after an edge; result settles one edge later
  task automatic step(input rsx_op_t op, input logic d, input logic [4:0] a,
                      input logic [7:0] f, input logic [7:0] k);
    op_in = op;
    dest_in = d;
    file_addr_in = a;
    file_data_in = f;
    literal_in = k;
    exec_valid_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
  endtask : step
  task automatic flags(input logic c, input logic z);
    chk1(carry_out, c);
    chk1(zero_out, z);
  endtask : flags
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk8(w_out, `RSX_W_RESET);
    chk8(dir6_out, `RSX_DIR_RESET);
    chk8(dir7_out, `RSX_DIR_RESET);
    flags(`RSX_C_RESET, `RSX_Z_RESET);
    chk1(file_wr_en_out, 1'b0);
  endtask : t_reset
  task automatic t_xor_lit;
    step(RSX_OP_XOR_LITERAL, 1'b1, 5'h00, 8'h00, 8'h3c);
    chk8(w_out, 8'h3c);
    flags(1'b0, 1'b0);
    chk1(file_wr_en_out, 1'b0);
    step(RSX_OP_XOR_LITERAL, 1'b0, 5'h00, 8'h00, 8'h3c);
    chk8(w_out, 8'h00);
    flags(1'b0, 1'b1);
  endtask : t_xor_lit
  task automatic t_rotate;
    step(RSX_OP_ROTATE_RIGHT_CARRY, 1'b1, 5'h1f, 8'h81, 8'h00);
    chk1(file_wr_en_out, 1'b1);
    chk8({3'h0, file_wr_addr_out}, 8'h1f);
    chk8(file_wr_data_out, 8'h40);
    chk8(w_out, 8'h00);
    flags(1'b1, 1'b1);
    step(RSX_OP_ROTATE_RIGHT_CARRY, 1'b0, 5'h02, 8'h03, 8'h00);
    chk8(w_out, 8'h81);
    flags(1'b1, 1'b1);
    chk1(file_wr_en_out, 1'b0);
  endtask : t_rotate
  task automatic t_swap;
    step(RSX_OP_NIBBLE_SWAP, 1'b1, 5'h00, 8'h5a, 8'h00);
    chk8(file_wr_data_out, 8'ha5);
    chk8({3'h0, file_wr_addr_out}, 8'h00);
    chk8(w_out, 8'h81);
    step(RSX_OP_NIBBLE_SWAP, 1'b0, 5'h07, 8'hf0, 8'h00);
    chk8(w_out, 8'h0f);
    flags(1'b1, 1'b1);
  endtask : t_swap
  task automatic t_xor_file;
    step(RSX_OP_XOR_FILE, 1'b1, 5'h03, 8'h1e, 8'h00);
    chk8(file_wr_data_out, 8'h11);
    chk8(w_out, 8'h0f);
    flags(1'b1, 1'b0);
    step(RSX_OP_XOR_FILE, 1'b0, 5'h03, 8'h0f, 8'h00);
    chk8(w_out, 8'h00);
    flags(1'b1, 1'b1);
  endtask : t_xor_file
  task automatic t_dir;
    step(RSX_OP_XOR_LITERAL, 1'b0, 5'h00, 8'h00, 8'h5a);
    step(RSX_OP_PORT_DIRECTION_LOAD, 1'b1, 5'h06, 8'h00, 8'h06);
    chk8(dir6_out, 8'h5a);
    chk8(dir7_out, 8'hff);
    flags(1'b1, 1'b0);
    step(RSX_OP_PORT_DIRECTION_LOAD, 1'b0, 5'h05, 8'h00, 8'h05);
    chk8(dir6_out, 8'h5a);
    chk8(dir7_out, 8'hff);
    step(RSX_OP_PORT_DIRECTION_LOAD, 1'b0, 5'h07, 8'h00, 8'h07);
    chk8(dir7_out, 8'h5a);
    chk8(w_out, 8'h5a);
    chk1(file_wr_en_out, 1'b0);
    // Valid low: the offered xor must be ignored
    op_in = RSX_OP_XOR_LITERAL;
    literal_in = 8'hff;
    exec_valid_in = 1'b0;
    @(posedge sys_clk_in);
    #1;
    chk8(w_out, 8'h5a);
  endtask : t_dir
  task automatic t_rerun;
    reset_n_in = 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #1;
    t_reset();
    reset_n_in = 1'b1;
    step(RSX_OP_XOR_LITERAL, 1'b0, 5'h00, 8'h00, 8'h81);
    chk8(w_out, 8'h81);
    flags(1'b0, 1'b0);
  endtask : t_rerun
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge sys_clk_in);
    #1;
    t_reset();
    reset_n_in = 1'b1;
    t_xor_lit();
    t_rotate();
    t_swap();
    t_xor_file();
    t_dir();
    t_rerun();
    summarize();
  end
  // Hang guard
  initial begin
    #100000;
    fails++;
    summarize();
  end
endmodule : rsx_exec_tb

// ### rsx_params.svh
/*
 Timing-free constants for the rotate/swap/xor/direction-load datapath.
 Assumes inclusion by bare name from the datapath files and the bench.
*/
`ifndef RSX_PARAMS_SVH
`define RSX_PARAMS_SVH
`define RSX_DATA_W 8
`define RSX_ADDR_W 5
`define RSX_DEST_W_SEL 1'b0
`define RSX_DEST_F_SEL 1'b1
`define RSX_DIR_SEL_LO 3'h6
`define RSX_DIR_SEL_HI 3'h7
`define RSX_W_RESET 8'h00
`define RSX_DIR_RESET 8'hff
`define RSX_C_RESET 1'b0
`define RSX_Z_RESET 1'b0
`endif

// ### rsx_pkg.sv
/*
 Types shared by the datapath: the operation selector.
 Assumes rsx_params.svh is on the include path.
*/
package rsx_pkg;
  typedef enum logic [2:0] {
    RSX_OP_NONE = 3'b000,
    RSX_OP_ROTATE_RIGHT_CARRY = 3'b001,
    RSX_OP_NIBBLE_SWAP = 3'b010,
    RSX_OP_PORT_DIRECTION_LOAD = 3'b011,
    RSX_OP_XOR_FILE = 3'b100,
    RSX_OP_XOR_LITERAL = 3'b101
  } rsx_op_t;
endpackage : rsx_pkg
